// ---- ccp_pkg.sv ----
// shared constants, types and helpers of the proximity card link
`default_nettype none
package ccp_pkg;
  // ----------------------------------------------------------------
  // link symbols and card states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SYM_NONE, SYM_ZERO, SYM_ONE, SYM_START} ccp_sym_t;
  typedef enum logic [2:0] {ST_IDLE, ST_READY1, ST_READY2, ST_ACTIVE, ST_AUTH, ST_HALT}
    ccp_state_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int BIT_TIME_NS = 9440;
  localparam int BIT_CYCLES = BIT_TIME_NS * CLK_MHZ / 1000;
  localparam int RESP_WAIT_US = 1000;
  localparam int RESP_WAIT_CYCLES = RESP_WAIT_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // block check
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'h6363;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [4:0] CRC_BYTES = 5'h02;
  localparam logic [4:0] MIN_FRAME_BYTES = 5'h03;

  // ----------------------------------------------------------------
  // command and answer codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_REQA = 8'h26;
  localparam logic [7:0] CMD_WUPA = 8'h52;
  localparam logic [7:0] CMD_HLTA = 8'h50;
  localparam logic [7:0] HLTA_ARG = 8'h00;
  localparam logic [7:0] SEL_CL1 = 8'h93;
  localparam logic [7:0] SEL_CL2 = 8'h95;
  localparam logic [7:0] NVB_ANTICOLL = 8'h20;
  localparam logic [7:0] NVB_SELECT = 8'h70;
  localparam logic [7:0] CASCADE_TAG = 8'h88;
  localparam logic [7:0] CMD_READ = 8'h30;
  localparam logic [7:0] CMD_WRITE = 8'hA2;
  localparam logic [7:0] PASSWORD_AUTHENTICATE_CMD = 8'h1B;
  localparam logic [7:0] COUNTER_READ_CMD = 8'h39;
  localparam logic [7:0] COUNTER_INCREMENT_CMD = 8'hA5;
  localparam logic [15:0] ATQA_VALUE = 16'h0044;
  localparam logic [7:0] SAK_CASCADE = 8'h04;
  localparam logic [7:0] SAK_DONE = 8'h00;
  localparam logic [7:0] ACK_CODE = 8'h0A;

  // ----------------------------------------------------------------
  // memory map and reset values
  // ----------------------------------------------------------------
  localparam int PAGES_SMALL = 20;
  localparam int PAGES_LARGE = 41;
  localparam int PAGE_SERIAL0 = 0;
  localparam int PAGE_SERIAL1 = 1;
  localparam int PAGE_LOCK = 2;
  localparam int PAGE_OTP = 3;
  localparam int PAGE_USER_FIRST = 4;
  localparam int PAGE_CFG_FIRST_SMALL = 16;
  localparam int SECRET_PAGE_FROM_END = 2;
  localparam int ACK_PAGE_FROM_END = 1;
  localparam int READ_PAGES = 4;
  localparam int NUM_COUNTERS = 3;
  localparam int COUNTER_BITS = 24;
  localparam int CARD_RX_BYTES = 9;
  localparam int CARD_TX_BYTES = 16;
  localparam int READER_TX_BYTES = 7;
  localparam int READER_RX_BYTES = 18;
  localparam logic [7:0] INTERNAL_RESET = 8'h00;
  localparam logic [15:0] LOCK_RESET = 16'h0000;
  localparam logic [31:0] SECRET_RESET = 32'hFFFFFFFF;
  localparam logic [15:0] ACK_VALUE_RESET = 16'h0000;
  localparam logic [15:0] RESERVED_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one byte into the running block check, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // odd parity bit of a byte
  function automatic logic odd_parity(input logic [7:0] b);
    return ~^b;
  endfunction
endpackage
`default_nettype wire

// ---- ccp_link_if.sv ----
// symbol link between reader and card, one strobed lane each way
`timescale 1ns/1ps
`default_nettype none
interface ccp_link_if;
  ccp_pkg::ccp_sym_t pcd_sym;
  logic pcd_stb;
  ccp_pkg::ccp_sym_t picc_sym;
  logic picc_stb;
  modport card (input pcd_sym, input pcd_stb, output picc_sym, output picc_stb);
  modport reader (output pcd_sym, output pcd_stb, input picc_sym, input picc_stb);
endinterface
`default_nettype wire

// ---- ccp_card.sv ----
// card end: symbol framer, deframer and protocol state machine
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// framer: start, bytes with parity, block check, end symbol
// ------------------------------------------------------------------
module ccp_sym_tx import ccp_pkg::*; #(
  parameter int NB = 16,
  parameter int BIT_CYC = BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [4:0] len,
  input wire logic [NB*8-1:0] data,
  output logic busy,
  output var ccp_sym_t sym,
  output logic stb
);
  localparam int DW = $clog2(BIT_CYC + 1);
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_END} ccp_tx_ph_t;
  typedef struct packed {
    ccp_tx_ph_t ph;
    logic [DW-1:0] div;
    logic [NB*8-1:0] dat;
    logic [4:0] len;
    logic [4:0] idx;
    logic [3:0] bitn;
    logic [15:0] crc;
    ccp_sym_t sym;
    logic stb;
  } ccp_tx_t;
  ccp_tx_t q, d;
  logic tick;
  logic [7:0] cur;

  // one symbol per bit period; data bytes then the two check bytes
  always_comb begin
    d = q;
    d.stb = 1'b0;
    tick = (q.div == DW'(BIT_CYC - 1));
    cur = (q.idx < q.len) ? q.dat[q.idx*8 +: 8] :
          (q.idx == q.len) ? q.crc[7:0] : q.crc[15:8];
    if (q.ph != TX_IDLE) begin
      d.div = tick ? '0 : q.div + 1'b1;
    end
    unique case (q.ph)
      TX_IDLE: if (go) begin
        d.ph = TX_START;
        d.dat = data;
        d.len = len;
        d.idx = '0;
        d.bitn = '0;
        d.crc = CRC_INIT;
        d.div = '0;
      end
      TX_START: if (tick) begin
        d.sym = SYM_START;
        d.stb = 1'b1;
        d.ph = TX_BITS;
      end
      TX_BITS: if (tick) begin
        d.stb = 1'b1;
        d.bitn = q.bitn + 4'h1;
        if (q.bitn == 4'h8) begin
          d.sym = odd_parity(cur) ? SYM_ONE : SYM_ZERO;
          d.bitn = '0;
          d.idx = q.idx + 5'h01;
          if (q.idx < q.len) d.crc = crc_step(q.crc, cur);
          if (q.idx == q.len + 5'h01) d.ph = TX_END;
        end else begin
          d.sym = cur[q.bitn[2:0]] ? SYM_ONE : SYM_ZERO;
        end
      end
      TX_END: if (tick) begin
        d.sym = SYM_NONE;
        d.stb = 1'b1;
        d.ph = TX_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) q <= '0;
    else q <= d;
  end

  assign busy = (q.ph != TX_IDLE);
  assign sym = q.sym;
  assign stb = q.stb;
endmodule

// ------------------------------------------------------------------
// deframer: checks parity, bit count and block check
// ------------------------------------------------------------------
module ccp_sym_rx import ccp_pkg::*; #(
  parameter int NB = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic stb,
  input wire ccp_sym_t sym,
  output logic done,
  output logic ok,
  output logic [4:0] nbytes,
  output logic [NB*8-1:0] data
);
  typedef struct packed {
    logic inf;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [4:0] cnt;
    logic [15:0] crc;
    logic err;
    logic [NB*8-1:0] dat;
    logic done;
    logic ok;
  } ccp_rx_t;
  ccp_rx_t q, d;

  // a start mid-frame restarts it; symbols outside a frame are dropped
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (stb) begin
      unique case (sym)
        SYM_START: begin
          d.inf = 1'b1;
          d.bitn = '0;
          d.cnt = '0;
          d.crc = CRC_INIT;
          d.err = 1'b0;
        end
        SYM_NONE: if (q.inf) begin
          d.inf = 1'b0;
          d.done = 1'b1;
          d.ok = !q.err && (q.bitn == 4'h0) && (q.crc == CRC_RESIDUE) &&
                 (q.cnt >= MIN_FRAME_BYTES);
        end
        SYM_ZERO, SYM_ONE: if (q.inf) begin
          if (q.bitn == 4'h8) begin
            if ((sym == SYM_ONE) != odd_parity(q.sh)) d.err = 1'b1;
            d.crc = crc_step(q.crc, q.sh);
            if (q.cnt < NB) d.dat[q.cnt*8 +: 8] = q.sh;
            else d.err = 1'b1;
            d.cnt = q.cnt + 5'h01;
            d.bitn = '0;
          end else begin
            d.sh = {sym == SYM_ONE, q.sh[7:1]};
            d.bitn = q.bitn + 4'h1;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) q <= '0;
    else q <= d;
  end

  assign done = q.done;
  assign ok = q.ok;
  assign nbytes = q.cnt;
  assign data = q.dat;
endmodule

// ------------------------------------------------------------------
// card protocol engine
// ------------------------------------------------------------------
module ccp_card import ccp_pkg::*; #(
  parameter int PAGES = PAGES_SMALL,
  parameter int BIT_CYC = BIT_CYCLES,
  parameter logic [7:0] PROT_FIRST = 8'hFF,
  parameter logic [55:0] UID = 56'h66554433221101 // arbitrary serial number
) (
  input wire logic CLK,
  input wire logic RESET,
  ccp_link_if.card LINK,
  output logic [2:0] CARD_STATE,
  output logic WAIT_IS_HALT,
  output logic FRAME_ERROR
);
  localparam int SECRET_PG = PAGES - SECRET_PAGE_FROM_END;
  localparam int ACK_PG = PAGES - ACK_PAGE_FROM_END;
  localparam logic [7:0] BCC0 = CASCADE_TAG ^ UID[7:0] ^ UID[15:8] ^ UID[23:16];
  localparam logic [7:0] BCC1 = UID[31:24] ^ UID[39:32] ^ UID[47:40] ^ UID[55:48];
  typedef struct packed {
    ccp_state_t st;
    logic halt_wait;
    logic [PAGES-1:0][31:0] mem;
    logic [NUM_COUNTERS-1:0][COUNTER_BITS-1:0] cnt;
    logic go;
    logic [4:0] tlen;
    logic [CARD_TX_BYTES*8-1:0] tdat;
    logic err;
  } ccp_card_t;

  // power-on image: serial, internal, lock, secret, acknowledge value
  function automatic ccp_card_t card_init();
    ccp_card_t s;
    s = '0;
    s.st = ST_IDLE;
    s.mem[PAGE_SERIAL0] = {BCC0, UID[23:0]};
    s.mem[PAGE_SERIAL1] = UID[55:24];
    s.mem[PAGE_LOCK] = {LOCK_RESET, INTERNAL_RESET, BCC1};
    s.mem[SECRET_PG] = SECRET_RESET;
    s.mem[ACK_PG] = {RESERVED_RESET, ACK_VALUE_RESET};
    return s;
  endfunction
  localparam ccp_card_t CARD_RST = card_init();

  // page addressable and, if protected, only once authenticated
  function automatic logic page_ok(input logic [7:0] pg, input logic auth);
    return (pg < PAGES) && (auth || pg < PROT_FIRST);
  endfunction

  ccp_card_t q, d;
  logic tx_busy;
  logic rx_done;
  logic rx_ok;
  logic [4:0] rx_n;
  logic [CARD_RX_BYTES*8-1:0] rx_dat;

  ccp_sym_rx #(.NB(CARD_RX_BYTES)) u_rx (
    .clk(CLK), .rst(RESET), .stb(LINK.pcd_stb), .sym(LINK.pcd_sym),
    .done(rx_done), .ok(rx_ok), .nbytes(rx_n), .data(rx_dat)
  );
  ccp_sym_tx #(.NB(CARD_TX_BYTES), .BIT_CYC(BIT_CYC)) u_tx (
    .clk(CLK), .rst(RESET), .go(q.go), .len(q.tlen), .data(q.tdat),
    .busy(tx_busy), .sym(LINK.picc_sym), .stb(LINK.picc_stb)
  );

  // frame decode; frames arriving while answering are ignored
  always_comb begin
    logic [7:0] c0;
    logic [7:0] c1;
    logic [4:0] n;
    logic [7:0] pg;
    logic [39:0] uidw;
    logic [127:0] rdat;
    logic [COUNTER_BITS:0] sum;
    ccp_state_t fb;
    c0 = rx_dat[7:0];
    c1 = rx_dat[15:8];
    n = rx_n - CRC_BYTES;
    pg = '0;
    rdat = '0;
    fb = q.halt_wait ? ST_HALT : ST_IDLE;
    uidw = (q.st == ST_READY1) ? {q.mem[PAGE_SERIAL0], CASCADE_TAG} :
           {q.mem[PAGE_LOCK][7:0], q.mem[PAGE_SERIAL1]};
    sum = {1'b0, q.cnt[c1[1:0]]} + {1'b0, rx_dat[39:16]};
    // four pages from the start address, wrapping at the end
    for (int k = 0; k < READ_PAGES; k++) begin
      pg = c1 + 8'(k);
      if (pg >= PAGES) pg = pg - 8'(PAGES);
      if (pg >= PAGES) pg = '0;
      rdat[k*32 +: 32] = q.mem[pg];
    end
    d = q;
    d.go = 1'b0;
    d.err = 1'b0;
    if (rx_done && !tx_busy) begin
      d.tdat = '0;
      if (!rx_ok) begin
        d.err = 1'b1;
        if (q.st != ST_IDLE && q.st != ST_HALT) d.st = fb;
      end else begin
        unique case (q.st)
          ST_IDLE, ST_HALT: begin
            if (n == 5'h01 && (c0 == CMD_WUPA || (c0 == CMD_REQA && q.st == ST_IDLE))) begin
              d.st = ST_READY1;
              d.go = 1'b1;
              d.tlen = 5'h02;
              d.tdat[15:0] = ATQA_VALUE;
            end else begin
              d.err = 1'b1;
            end
          end
          ST_READY1, ST_READY2: begin
            if (n == 5'h02 && c0 == ((q.st == ST_READY1) ? SEL_CL1 : SEL_CL2) &&
                c1 == NVB_ANTICOLL) begin
              d.go = 1'b1;
              d.tlen = 5'h05;
              d.tdat[39:0] = uidw;
            end else if (n == 5'h07 && c0 == ((q.st == ST_READY1) ? SEL_CL1 : SEL_CL2) &&
                         c1 == NVB_SELECT && rx_dat[55:16] == uidw) begin
              d.st = (q.st == ST_READY1) ? ST_READY2 : ST_ACTIVE;
              d.go = 1'b1;
              d.tlen = 5'h01;
              d.tdat[7:0] = (q.st == ST_READY1) ? SAK_CASCADE : SAK_DONE;
            end else if (n == 5'h02 && c0 == CMD_READ && c1 == 8'h00) begin
              d.st = ST_ACTIVE;
              d.go = 1'b1;
              d.tlen = 5'h10;
              d.tdat = rdat;
            end else begin
              d.err = 1'b1;
              d.st = fb;
            end
          end
          ST_ACTIVE, ST_AUTH: begin
            if (n == 5'h02 && c0 == CMD_HLTA && c1 == HLTA_ARG) begin
              d.st = ST_HALT;
              d.halt_wait = 1'b1;
            end else if (n == 5'h02 && c0 == CMD_READ && page_ok(c1, q.st == ST_AUTH)) begin
              d.go = 1'b1;
              d.tlen = 5'h10;
              d.tdat = rdat;
            end else if (n == 5'h06 && c0 == CMD_WRITE && c1 >= PAGE_OTP &&
                         page_ok(c1, q.st == ST_AUTH)) begin
              d.mem[c1] = rx_dat[47:16];
              d.go = 1'b1;
              d.tlen = 5'h01;
              d.tdat[7:0] = ACK_CODE;
            end else if (n == 5'h05 && c0 == PASSWORD_AUTHENTICATE_CMD && q.st == ST_ACTIVE &&
                         rx_dat[39:8] == q.mem[SECRET_PG]) begin
              d.st = ST_AUTH;
              d.go = 1'b1;
              d.tlen = 5'h02;
              d.tdat[15:0] = q.mem[ACK_PG][15:0];
            end else if (n == 5'h02 && c0 == COUNTER_READ_CMD && c1 < NUM_COUNTERS) begin
              d.go = 1'b1;
              d.tlen = 5'h03;
              d.tdat[23:0] = q.cnt[c1[1:0]];
            end else if (n == 5'h06 && c0 == COUNTER_INCREMENT_CMD && c1 < NUM_COUNTERS &&
                         !sum[COUNTER_BITS]) begin
              d.cnt[c1[1:0]] = sum[COUNTER_BITS-1:0];
              d.go = 1'b1;
              d.tlen = 5'h01;
              d.tdat[7:0] = ACK_CODE;
            end else begin
              d.err = 1'b1;
              d.st = fb;
            end
          end
          default: begin
            d.st = fb;
          end
        endcase
      end
    end
  end

  // state register; power-on image held in flip-flops
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) q <= CARD_RST;
    else q <= d;
  end

  assign CARD_STATE = q.st;
  assign WAIT_IS_HALT = q.halt_wait;
  assign FRAME_ERROR = q.err;
endmodule
`default_nettype wire

// ---- ccp_reader.sv ----
// reader end: sends a command frame and collects the card answer
`timescale 1ns/1ps
`default_nettype none
module ccp_reader import ccp_pkg::*; #(
  parameter int BIT_CYC = BIT_CYCLES,
  parameter int WAIT_CYC = RESP_WAIT_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  ccp_link_if.reader LINK,
  input wire logic CMD_VALID,
  input wire logic [4:0] CMD_LEN,
  input wire logic [READER_TX_BYTES*8-1:0] CMD_DATA,
  output logic CMD_READY,
  output logic RESP_VALID,
  output logic RESP_OK,
  output logic RESP_TIMEOUT,
  output logic [4:0] RESP_LEN,
  output logic [READER_RX_BYTES*8-1:0] RESP_DATA
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RD_IDLE, RD_SEND, RD_WAIT} ccp_rd_ph_t;
  typedef struct packed {
    ccp_rd_ph_t ph;
    logic ready;
    logic go;
    logic [4:0] len;
    logic [READER_TX_BYTES*8-1:0] dat;
    logic [31:0] wcnt;
    logic rvalid;
    logic rok;
    logic rto;
    logic [4:0] rlen;
    logic [READER_RX_BYTES*8-1:0] rdat;
  } ccp_rd_t;
  ccp_rd_t q, d;
  logic tx_busy;
  logic rx_done;
  logic rx_ok;
  logic [4:0] rx_n;
  logic [READER_RX_BYTES*8-1:0] rx_dat;

  ccp_sym_tx #(.NB(READER_TX_BYTES), .BIT_CYC(BIT_CYC)) u_tx (
    .clk(CLK), .rst(RESET), .go(q.go), .len(q.len), .data(q.dat),
    .busy(tx_busy), .sym(LINK.pcd_sym), .stb(LINK.pcd_stb)
  );
  ccp_sym_rx #(.NB(READER_RX_BYTES)) u_rx (
    .clk(CLK), .rst(RESET), .stb(LINK.picc_stb), .sym(LINK.picc_sym),
    .done(rx_done), .ok(rx_ok), .nbytes(rx_n), .data(rx_dat)
  );

  // ----------------------------------------------------------------
  // one command in flight; answers outside the wait window are dropped
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.go = 1'b0;
    d.rvalid = 1'b0;
    unique case (q.ph)
      RD_IDLE: begin
        if (q.ready && CMD_VALID) begin
          d.ready = 1'b0;
          d.go = 1'b1;
          d.len = CMD_LEN;
          d.dat = CMD_DATA;
          d.ph = RD_SEND;
        end else if (!q.go && !q.rvalid && !CMD_VALID) begin
          d.ready = 1'b1; // first idle cycle after reset
        end
      end
      RD_SEND: if (!q.go && !tx_busy) begin
        d.ph = RD_WAIT;
        d.wcnt = '0;
      end
      RD_WAIT: begin
        d.wcnt = q.wcnt + 32'h1;
        if (rx_done) begin
          d.rvalid = 1'b1;
          d.rok = rx_ok;
          d.rto = 1'b0;
          d.rlen = rx_ok ? rx_n - CRC_BYTES : 5'h00;
          d.rdat = rx_dat;
          d.ready = 1'b1;
          d.ph = RD_IDLE;
        end else if (q.wcnt == 32'(WAIT_CYC - 1)) begin
          d.rvalid = 1'b1; // silent card, e.g. after halt
          d.rok = 1'b0;
          d.rto = 1'b1;
          d.rlen = 5'h00;
          d.ready = 1'b1;
          d.ph = RD_IDLE;
        end
      end
      default: d.ph = RD_IDLE;
    endcase
  end

  // state register; ready rises on the first edge after reset
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) q <= '0;
    else q <= d;
  end

  assign CMD_READY = q.ready;
  assign RESP_VALID = q.rvalid;
  assign RESP_OK = q.rok;
  assign RESP_TIMEOUT = q.rto;
  assign RESP_LEN = q.rlen;
  assign RESP_DATA = q.rdat;
endmodule
`default_nettype wire

// ---- ccp_monitor.sv ----
// link rule checker for the two symbol lanes
`timescale 1ns/1ps
`default_nettype none
module ccp_monitor import ccp_pkg::*; #(
  parameter int BC = 4
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire ccp_sym_t pcd_sym,
  input wire logic pcd_stb,
  input wire ccp_sym_t picc_sym,
  input wire logic picc_stb
);
  // ----
  // frame trackers, lane 0 reader, lane 1 card
  // ----
  logic [1:0] stb;
  logic [1:0] open_q;
  logic [1:0] par_q;
  logic [3:0] cnt_q [2];
  ccp_sym_t sym [2];
  assign stb = {picc_stb, pcd_stb};
  assign sym[0] = pcd_sym;
  assign sym[1] = picc_sym;
  // parity restarts per byte so one bad byte cannot mask the next
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      open_q <= 2'h0;
      par_q <= 2'h0;
      cnt_q <= '{4'h0, 4'h0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (stb[i]) begin
          open_q[i] <= sym[i] == SYM_START || (open_q[i] && sym[i] != SYM_NONE);
          par_q[i] <= sym[i] != SYM_START && cnt_q[i] != 4'h8 && (par_q[i] ^ (sym[i] == SYM_ONE));
          cnt_q[i] <= (sym[i] == SYM_START || cnt_q[i] == 4'h8) ? 4'h0 : cnt_q[i] + 4'h1;
        end
      end
    end
  end
  // ----
  // lane rules
  // ----
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RESET);
  sequence s_card_bit;
    picc_stb && picc_sym != SYM_NONE;
  endsequence
  sequence s_card_start;
    picc_stb && picc_sym == SYM_START;
  endsequence
  a_pcd_pace: assert property (pcd_stb && pcd_sym != SYM_NONE |-> ##BC pcd_stb)
    else $error("reader pace");
  a_card_pace: assert property (s_card_bit |-> ##BC picc_stb)
    else $error("card pace");
  a_pcd_held: assert property (!pcd_stb |-> $stable(pcd_sym))
    else $error("reader symbol moved");
  a_pcd_start_bit: assert property (stb[0] && !open_q[0] |-> sym[0] == SYM_START)
    else $error("reader start");
  a_card_start_bit: assert property (stb[1] && !open_q[1] |-> sym[1] == SYM_START)
    else $error("card start");
  a_pcd_odd_par: assert property (stb[0] && open_q[0] && cnt_q[0] == 4'h8 |->
    sym[0] == (par_q[0] ? SYM_ZERO : SYM_ONE)) else $error("reader parity");
  a_card_odd_par: assert property (stb[1] && open_q[1] && cnt_q[1] == 4'h8 |->
    sym[1] == (par_q[1] ? SYM_ZERO : SYM_ONE)) else $error("card parity");
  a_pcd_bit_count: assert property (stb[0] && open_q[0] && sym[0] == SYM_NONE |->
    cnt_q[0] == 4'h0) else $error("reader bit count");
  a_card_bit_count: assert property (stb[1] && open_q[1] && sym[1] == SYM_NONE |->
    cnt_q[1] == 4'h0) else $error("card bit count");
  a_answer_gap: assert property (s_card_start |->
    $past(pcd_stb && pcd_sym == SYM_NONE, BC + 3)) else $error("card answer gap");
endmodule
`default_nettype wire

// ---- tb_ccp.sv ----
// self-checking bench: reader and card joined over the symbol link
`timescale 1ns/1ps
`default_nettype none
module tb_ccp import ccp_pkg::*;;
  // ----
  // set-up
  // ----
  localparam int BC = 4;
  localparam logic [55:0] UID = 56'hC3B2A1F0E9D8C7; // arbitrary serial number
  localparam logic [7:0] PROT = 8'h10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [4:0] cmd_len = 5'h01;
  logic [55:0] cmd_data = 56'h0;
  logic cmd_ready, resp_valid, resp_ok, resp_timeout, wh, ferr;
  int ferrs = 0;
  logic hx = 1'b0;
  logic [2:0] card_state;
  logic [4:0] resp_len;
  logic [143:0] resp_data;
  int mismatches = 0;
  int comparisons = 0;
  logic [31:0] r = 32'h7;
  logic [39:0] ac1, ac2;
  logic [127:0] rd0;
  ccp_link_if ccp_link_if_i ();
  ccp_card #(.BIT_CYC(BC), .PROT_FIRST(PROT), .UID(UID)) ccp_card_i (.CLK(clk),
    .RESET(rst), .LINK(ccp_link_if_i.card), .CARD_STATE(card_state),
    .WAIT_IS_HALT(wh), .FRAME_ERROR(ferr));
  ccp_reader #(.BIT_CYC(BC), .WAIT_CYC(800)) ccp_reader_i (.CLK(clk), .RESET(rst),
    .LINK(ccp_link_if_i.reader), .CMD_VALID(cmd_valid), .CMD_LEN(cmd_len),
    .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .RESP_VALID(resp_valid), .RESP_OK(resp_ok),
    .RESP_TIMEOUT(resp_timeout), .RESP_LEN(resp_len), .RESP_DATA(resp_data));
  ccp_monitor #(.BC(BC)) ccp_monitor_i (.CLK(clk), .RESET(rst),
    .pcd_sym(ccp_link_if_i.pcd_sym), .pcd_stb(ccp_link_if_i.pcd_stb),
    .picc_sym(ccp_link_if_i.picc_sym), .picc_stb(ccp_link_if_i.picc_stb));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // error pulses stand one cycle, so count them at every edge
  always @(posedge clk) begin
    if (ferr === 1'b1) ferrs++;
  end
  // xorshift source and uid check byte
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] bcc(input logic [31:0] w);
    return w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
  endfunction
  // ----
  // drivers and compares, all moved 1 ns after the edge
  // ----
  task automatic bad(input string m);
    mismatches++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic cmp_state(input ccp_state_t st);
    comparisons++;
    if ({wh, card_state} !== {hx, 3'(st)}) bad("card state");
  endtask
  task automatic cmp_resp(input int n, input logic [127:0] e);
    logic [127:0] m;
    m = (128'h1 << (8 * n)) - 128'h1;
    comparisons++;
    if (n == 0 && resp_timeout !== 1'b1) bad("unexpected answer");
    if (n != 0 && (resp_ok !== 1'b1 || resp_len !== 5'(n) || (resp_data[127:0] & m) !== e))
      bad("answer differs");
  endtask
  task automatic cmp_errs(input int e);
    comparisons++;
    if (ferrs != e) bad("frame error count");
  endtask
  // one command, then its answer or silence, then the state
  task automatic step(input logic [4:0] n, input logic [55:0] d, input int rn,
    input logic [127:0] re, input ccp_state_t st);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      tick;
      k++;
    end
    cmd_valid = 1'b1;
    cmd_len = n;
    cmd_data = d;
    tick;
    cmd_valid = 1'b0;
    k = 0;
    while (resp_valid !== 1'b1 && k < 2000) begin
      tick;
      k++;
    end
    if (k == 2000) bad("no answer");
    cmp_resp(rn, re);
    cmp_state(st);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog well past the longest command sequence
  initial begin
    #450000;
    bad("watchdog");
    wrap_up;
  end
  // ----
  // tests
  // ----
  initial begin
    ac1 = {bcc({UID[23:0], CASCADE_TAG}), UID[23:0], CASCADE_TAG};
    ac2 = {bcc(UID[55:24]), UID[55:24]};
    rd0 = {32'h0, LOCK_RESET, INTERNAL_RESET, ac2[39:32], UID[55:24], ac1[39:8]};
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    cmp_state(ST_IDLE);
    for (int i = 0; i < 4; i++) begin
      r = xs(r);
      if (r[7:0] == CMD_REQA || r[7:0] == CMD_WUPA) r[7:0] = ~r[7:0];
      step(5'(1 + r[9:8] % 3), 56'(r), 0, 128'h0, ST_IDLE);
    end
    step(5'h01, 56'(CMD_REQA), 2, 128'(ATQA_VALUE), ST_READY1);
    step(5'h02, 56'({NVB_ANTICOLL, SEL_CL1}), 5, 128'(ac1), ST_READY1);
    step(5'h07, {ac1, NVB_SELECT, SEL_CL1}, 1, 128'(SAK_CASCADE), ST_READY2);
    step(5'h02, 56'({NVB_ANTICOLL, SEL_CL2}), 5, 128'(ac2), ST_READY2);
    step(5'h07, {ac2, NVB_SELECT, SEL_CL2}, 1, 128'(SAK_DONE), ST_ACTIVE);
    $display("test select done");
    step(5'h02, 56'({8'h00, CMD_READ}), 16, rd0, ST_ACTIVE);
    step(5'h02, 56'({PROT, CMD_READ}), 0, 128'h0, ST_IDLE);
    step(5'h01, 56'(CMD_REQA), 2, 128'(ATQA_VALUE), ST_READY1);
    step(5'h02, 56'({8'h00, CMD_READ}), 16, rd0, ST_ACTIVE);
    step(5'h05, 56'({SECRET_RESET, PASSWORD_AUTHENTICATE_CMD}), 2, 128'h0, ST_AUTH);
    step(5'h02, 56'({8'h12, CMD_READ}), 16, {rd0[63:0], 32'h0, SECRET_RESET}, ST_AUTH);
    r = xs(r);
    step(5'h06, 56'({r, 8'h13, CMD_WRITE}), 1, 128'(ACK_CODE), ST_AUTH);
    step(5'h02, 56'({8'h00, COUNTER_READ_CMD}), 3, 128'h0, ST_AUTH);
    hx = 1'b1;
    step(5'h02, 56'({HLTA_ARG, CMD_HLTA}), 0, 128'h0, ST_HALT);
    $display("test memory done");
    step(5'h01, 56'(CMD_REQA), 0, 128'h0, ST_HALT);
    step(5'h01, 56'(CMD_WUPA), 2, 128'(ATQA_VALUE), ST_READY1);
    step(5'h02, 56'({8'h05, CMD_READ}), 0, 128'h0, ST_HALT);
    step(5'h01, 56'(CMD_WUPA), 2, 128'(ATQA_VALUE), ST_READY1);
    step(5'h02, 56'({8'h00, CMD_READ}), 16, rd0, ST_ACTIVE);
    step(5'h05, 56'({SECRET_RESET, PASSWORD_AUTHENTICATE_CMD}), 2, 128'(r[15:0]), ST_AUTH);
    step(5'h02, 56'({8'h14, CMD_READ}), 0, 128'h0, ST_HALT);
    $display("test halt done");
    cmp_errs(8);
    wrap_up;
  end
endmodule
`default_nettype wire
